// file: iepr_chk.sv
// Port checker for the enable/priority block
`timescale 1ns/1ps
// ****
// Checker
// ****
module iepr_chk (
  // Clock, reset, bus
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Sources
  input wire [33:0] src_flag,
  input wire [33:0] src_req,
  input wire [101:0] src_level
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_req_flag;
    ~|(src_req & ~$past(src_flag));
  endproperty
  a_req_flag: assert property (p_req_flag)
    else $error("request without flag");
  property p_req_lvl;
    src_req[18] |-> src_level[56:54] != 3'h0;
  endproperty
  a_req_lvl: assert property (p_req_lvl)
    else $error("request at level zero");
  property p_pair_lvl;
    src_req[0] |-> src_level[2:0] == 3'h7;
  endproperty
  a_pair_lvl: assert property (p_pair_lvl)
    else $error("fixed level wrong");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
  // Same-cycle address and data give the answer two edges on
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("bvalid late");
  property p_r_time;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_time: assert property (p_r_time) else $error("rvalid late");
  property p_rdy_low;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_rdy_low: assert property (p_rdy_low) else $error("ready during answer");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_req: cover property (src_req[18]);
endmodule // iepr_chk

bind iepr_core iepr_chk iepr_chk_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .src_flag, .src_req,
  .src_level);

// file: iepr_core.v
// Interrupt enable and priority registers with AXI4-Lite access
`timescale 1ns/1ps
`include "iepr_regs.vh"

module iepr_core (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Source flags, bit n is source n
  input wire [`IEPR_NSRC-1:0] src_flag,
  // Requests to arbitration and their levels
  output reg [`IEPR_NSRC-1:0] src_req,
  output reg [3*`IEPR_NSRC-1:0] src_level,
  // Interrupt line
  output reg irq
);

  // ****************************************
  // Register storage
  // ****************************************
  reg [15:0] ena_hi_reg;
  reg [15:0] ena_lo_reg;
  reg [15:0] prio_reg [0:5];
  reg [1:0] stat_reg;
  reg [1:0] mask_reg;

  // Write channel capture
  reg aw_have_reg;
  reg w_have_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire [15:0] wmask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [15:0] wval = w_data_reg[15:0];
  wire do_read = s_axi_arvalid && s_axi_arready;

  // ****************************************
  // Source map
  // ****************************************
  // Enables: 0..5 adc pairs 2..7, 6..12 pwm gens 3..9,
  // 13..15 comparators 2..4, 16..17 adc pairs 0..1.
  // Priorities: sources 18..33 use fields of prio regs.
  wire [33:0] en_vec = {16'hFFFF, ena_hi_reg[15:14], ena_hi_reg[9:0],
    ena_lo_reg[5:0]};
  wire [95:0] prio_flat = {prio_reg[5], prio_reg[4], prio_reg[3],
    prio_reg[2], prio_reg[1], prio_reg[0]};
  wire [1:0] ev_vec;

  genvar gi;
  generate
    for (gi = 0; gi < `IEPR_NSRC; gi = gi + 1) begin : g_src
      wire [2:0] lvl;
      if (gi < 18) begin : g_en_only
        assign lvl = 3'h7;
      end else begin : g_prio
        // Four fields per register, nibble steps
        assign lvl = prio_flat[(gi-18)*4 +: 3];
      end
      always @(posedge aclk) begin
        if (!aresetn) begin
          src_req[gi] <= 1'b0;
          src_level[3*gi +: 3] <= 3'h0;
        end else begin
          // Request only with flag, enable and nonzero level
          src_req[gi] <= src_flag[gi] && en_vec[gi] &&
            (lvl != 3'h0);
          src_level[3*gi +: 3] <= lvl;
        end
      end
    end
  endgenerate

  // Events: any enabled flag, any blocked flag
  assign ev_vec[0] = |(src_flag & en_vec);
  assign ev_vec[1] = |(src_flag & ~en_vec);

  // ****************************************
  // Write path
  // ****************************************
  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IEPR_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      ena_hi_reg <= `IEPR_ENA_RST;
      ena_lo_reg <= `IEPR_ENA_RST;
      for (k = 0; k < 6; k = k + 1) begin
        prio_reg[k] <= `IEPR_PRIO_RST;
      end
      prio_reg[3] <= `IEPR_PRIO3_RST;
      // Last two priority registers keep only their upper byte here
      prio_reg[4] <= `IEPR_PRIO5_RST;
      prio_reg[5] <= `IEPR_PRIO5_RST;
      mask_reg <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `IEPR_RESP_OKAY;
        // Masks keep unimplemented bits at zero
        case (aw_addr_reg)
          `IEPR_ENA_HI_OFF: ena_hi_reg <= (ena_hi_reg & ~wmask) |
            (wval & wmask & `IEPR_ENA_HI_MASK);
          `IEPR_ENA_LO_OFF: ena_lo_reg <= (ena_lo_reg & ~wmask) |
            (wval & wmask & `IEPR_ENA_LO_MASK);
          `IEPR_PRIO0_OFF: prio_reg[0] <= (prio_reg[0] & ~wmask) |
            (wval & wmask & `IEPR_PRIO_MASK);
          `IEPR_PRIO1_OFF: prio_reg[1] <= (prio_reg[1] & ~wmask) |
            (wval & wmask & `IEPR_PRIO_MASK);
          `IEPR_PRIO2_OFF: prio_reg[2] <= (prio_reg[2] & ~wmask) |
            (wval & wmask & `IEPR_PRIO_MASK);
          `IEPR_PRIO3_OFF: prio_reg[3] <= (prio_reg[3] & ~wmask) |
            (wval & wmask & `IEPR_PRIO3_MASK);
          `IEPR_PRIO4_OFF: begin
            prio_reg[4] <= (prio_reg[4] & ~wmask) |
              (wval & wmask & `IEPR_PRIO5_MASK);
          end
          `IEPR_PRIO5_OFF: prio_reg[5] <= (prio_reg[5] & ~wmask) |
            (wval & wmask & `IEPR_PRIO5_MASK);
          `IEPR_MASK_OFF: begin
            if (w_strb_reg[0]) begin
              mask_reg <= w_data_reg[1:0];
            end
          end
          `IEPR_FLAG_HI_OFF, `IEPR_FLAG_LO_OFF, `IEPR_STAT_OFF: begin
          end
          default: s_axi_bresp <= `IEPR_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  reg [31:0] rd_val;
  reg rd_ok;
  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `IEPR_ENA_HI_OFF: rd_val[15:0] = ena_hi_reg;
      `IEPR_ENA_LO_OFF: rd_val[15:0] = ena_lo_reg;
      `IEPR_PRIO0_OFF: rd_val[15:0] = prio_reg[0];
      `IEPR_PRIO1_OFF: rd_val[15:0] = prio_reg[1];
      `IEPR_PRIO2_OFF: rd_val[15:0] = prio_reg[2];
      `IEPR_PRIO3_OFF: rd_val[15:0] = prio_reg[3];
      `IEPR_PRIO4_OFF: rd_val[15:0] = prio_reg[4];
      `IEPR_PRIO5_OFF: rd_val[15:0] = prio_reg[5];
      `IEPR_FLAG_HI_OFF: rd_val[15:0] = {14'h0000, src_req[33:32]} |
        16'h0000;
      `IEPR_FLAG_LO_OFF: rd_val = src_req[31:0];
      `IEPR_STAT_OFF: rd_val[1:0] = stat_reg;
      `IEPR_MASK_OFF: rd_val[1:0] = mask_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IEPR_RESP_OKAY;
    end else begin
      if (do_read) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `IEPR_RESP_OKAY : `IEPR_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Sticky status and interrupt line
  // ****************************************
  // Set beats the clear so no event is lost
  wire stat_rd = do_read && (s_axi_araddr == `IEPR_STAT_OFF);
  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= 2'b00;
      irq <= 1'b0;
    end else begin
      stat_reg <= (stat_rd ? 2'b00 : stat_reg) | ev_vec;
      irq <= |(((stat_rd ? 2'b00 : stat_reg) | ev_vec) & mask_reg);
    end
  end

endmodule // iepr_core

// file: iepr_regs.vh
// Register offsets, field positions and reset values for the enable/priority block
`ifndef IEPR_REGS_VH
`define IEPR_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define IEPR_ENA_HI_OFF 8'h00
`define IEPR_ENA_LO_OFF 8'h04
`define IEPR_PRIO0_OFF 8'h08
`define IEPR_PRIO1_OFF 8'h0C
`define IEPR_PRIO2_OFF 8'h10
`define IEPR_PRIO3_OFF 8'h14
`define IEPR_PRIO4_OFF 8'h18
`define IEPR_PRIO5_OFF 8'h1C
`define IEPR_FLAG_HI_OFF 8'h20
`define IEPR_FLAG_LO_OFF 8'h24
`define IEPR_STAT_OFF 8'h28
`define IEPR_MASK_OFF 8'h2C

// ****************************************
// Write masks of implemented bits
// ****************************************
`define IEPR_ENA_HI_MASK 16'hC3FF
`define IEPR_ENA_LO_MASK 16'h003F
`define IEPR_PRIO_MASK 16'h7777
`define IEPR_PRIO3_MASK 16'h0777
`define IEPR_PRIO5_MASK 16'h7700

// ****************************************
// Reset values
// ****************************************
`define IEPR_ENA_RST 16'h0000
`define IEPR_PRIO_RST 16'h4444
`define IEPR_PRIO3_RST 16'h0444
`define IEPR_PRIO5_RST 16'h4400

// ****************************************
// Field positions and source count
// ****************************************
`define IEPR_DMA1_LSB 8
`define IEPR_TIMER_A_LSB 12
`define IEPR_NSRC 34

// ****************************************
// AXI responses
// ****************************************
`define IEPR_RESP_OKAY 2'b00
`define IEPR_RESP_SLVERR 2'b10

`endif

// file: test_interrupt_enable_priority_regs.sv
// Self-checking bench for the enable/priority block
`timescale 1ns/1ps
// ****
// Bench
// ****
module test_interrupt_enable_priority_regs;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [33:0] src_flag;
  reg [3:0] s_axi_wstrb;
  reg [39:0] tbl [0:5];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [33:0] src_req;
  wire [101:0] src_level;
  integer error_cnt = 0, n_tests = 0, i;
  iepr_core iepr_core_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_flag, .src_req,
    .src_level, .irq);
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // Extra edge first, so no strobe is set twice in one step
  task wr(input [7:0] a, input [15:0] d, input [1:0] e);
    integer k;
    reg dn;
    begin
      @(posedge aclk);
      dn = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (k = 0; k < 64 && !dn; k = k + 1) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          dn = 1'b1;
          s_axi_bready <= 1'b0;
          chk(s_axi_bresp, e);
        end
      end
      if (!dn) begin
        error_cnt = error_cnt + 1;
        close_out;
      end
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] r);
    integer k;
    reg dn;
    begin
      @(posedge aclk);
      dn = 1'b0;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (k = 0; k < 64 && !dn; k = k + 1) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          dn = 1'b1;
          s_axi_rready <= 1'b0;
          chk(s_axi_rdata, e);
          chk(s_axi_rresp, r);
        end
      end
      if (!dn) begin
        error_cnt = error_cnt + 1;
        close_out;
      end
    end
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, src_flag} = '0;
    s_axi_wstrb = 4'hf;
    tbl[0] = 40'h00_ffff_c3ff;
    tbl[1] = 40'h04_ffff_003f;
    tbl[2] = 40'h08_ffff_7777;
    tbl[3] = 40'h14_ffff_0777;
    tbl[4] = 40'h0c_0000_0000;
    tbl[5] = 40'h18_ffff_7700;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      wr(tbl[i][39:32], tbl[i][31:16], 2'b00);
      rd(tbl[i][39:32], {16'h0000, tbl[i][15:0]}, 2'b00);
    end
    $display("table done");
    // Second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h04, 32'h0000_0000, 2'b00);
    rd(8'h08, 32'h0000_4444, 2'b00);
    rd(8'h14, 32'h0000_0444, 2'b00);
    rd(8'h18, 32'h0000_4400, 2'b00);
    wr(8'h40, 16'hffff, 2'b10);
    rd(8'h40, 32'h0000_0000, 2'b10);
    $display("reset done");
    wr(8'h04, 16'h0001, 2'b00);
    wr(8'h2c, 16'h0001, 2'b00);
    src_flag <= 34'h0_0004_0001;
    repeat (2) @(posedge aclk);
    chk(src_req[0], 1);
    chk(src_req[18], 1);
    chk(irq, 1);
    wr(8'h08, 16'h4440, 2'b00);
    repeat (2) @(posedge aclk);
    chk(src_req[18], 0);
    wr(8'h08, 16'h4447, 2'b00);
    repeat (2) @(posedge aclk);
    chk(src_level[56:54], 7);
    wr(8'h04, 16'h0000, 2'b00);
    repeat (2) @(posedge aclk);
    chk(src_req[0], 0);
    src_flag <= 34'h0_0000_0000;
    repeat (2) @(posedge aclk);
    rd(8'h28, 32'h0000_0003, 2'b00);
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    src_flag <= 34'h0_0000_0001;
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    wr(8'h2c, 16'h0002, 2'b00);
    repeat (2) @(posedge aclk);
    chk(irq, 1);
    // Low byte strobe only: upper byte must keep its value
    s_axi_wstrb <= 4'h1;
    wr(8'h08, 16'h0000, 2'b00);
    rd(8'h08, 32'h0000_4400, 2'b00);
    s_axi_wstrb <= 4'hf;
    $display("requests done");
    close_out;
  end
endmodule // test_interrupt_enable_priority_regs
